// [hw/tsch_pkg.sv]
// constants and carrier types for the transmit scheduler and wall clock
// assumes a 25 MHz core clock and a 32-bit classic wishbone register bus
package tsch_pkg;
    localparam int SLOTS = 20;
    localparam int SLOT_W = 5;
    localparam int MAX_LEN = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int TICKS_PER_S = 1000 / TICK_MS;
    localparam int SYNC_S = 3600;
    localparam int ADJ_MAX = 129600;

    // global registers, byte addresses
    localparam logic [11:0] CTRL_OFS = 12'h0000;
    localparam logic [11:0] STAT_OFS = 12'h0004;
    localparam logic [11:0] PRESET_OFS = 12'h0008;
    localparam logic [11:0] ADJ_OFS = 12'h000C;
    localparam logic [11:0] WALL_OFS = 12'h0010;
    localparam logic [11:0] SYNCT_OFS = 12'h0014;
    // slot blocks: base + slot * stride, word index within block
    localparam logic [11:0] SLOT_BASE = 12'h0100;
    localparam int SLOT_STRIDE_SH = 5;
    localparam logic [2:0] S_CFG = 3'h0;
    localparam logic [2:0] S_ID = 3'h1;
    localparam logic [2:0] S_DLO = 3'h2;
    localparam logic [2:0] S_DHI = 3'h3;
    localparam logic [2:0] S_PER = 3'h4;
    localparam logic [2:0] S_DLY = 3'h5;

    // control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_CFG_DONE = 1;
    localparam int CTRL_SYNC_ON = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // slot config fields
    localparam int SCFG_EN = 0;
    localparam int SCFG_EXT = 1;
    localparam int SCFG_ROUTE_LO = 2;
    localparam int SCFG_LEN_LO = 4;
    localparam logic [7:0] SCFG_RST = 8'h00;
    localparam int STD_ID_W = 11;

    typedef struct packed {
        logic [SLOT_W-1:0] slot;
        logic [1:0] route;
        logic long_identifier_select;
        logic [28:0] frame_identifier;
        logic [3:0] len;
        logic [63:0] payload_bytes;
    } tsch_frame_t;

    typedef enum logic [2:0] {
        RTC_WAIT = 3'b001,
        RTC_ADJ = 3'b010,
        RTC_RUN = 3'b100
    } tsch_rtc_st_t;
endpackage

// [hw/tsch_fifo.sv]
// synchronous fifo with valid/ready on both sides
// assumes one clock; out_data_o is valid while out_valid_o is high
`timescale 1ns/1ps
module tsch_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    assign empty = (wr_r == rd_r);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_r[AW-1:0]];
    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end

    property p_full_holds;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        full && !out_ready_i |=> full && $stable(wr_r);
    endproperty
    a_full_holds: assert property (p_full_holds)
        else $error("fifo write pointer moved while full");

    property p_push_not_empty;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        push |=> out_valid_o;
    endproperty
    a_push_not_empty: assert property (p_push_not_empty)
        else $error("fifo empty after a push");
endmodule

// [hw/tsch_top.sv]
// transmit scheduler for twenty can frame slots plus the wall-time clock
// assumes a classic wishbone master, a can controller taking frames on a
// valid/ready handshake, and a backup-supplied reset for the wall clock
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module tsch_top #(
    parameter int TICK_CYCLES = tsch_pkg::TICK_CYC
) (
    // clock and resets
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic bkp_rst_b_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // frames to the can controller
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output tsch_pkg::tsch_frame_t tx_frame_o,
    output logic tx_log_copy_o,
    output logic tx_host_copy_o,
    // wall clock
    output logic [31:0] wall_time_o,
    output logic sync_req_o
);
    localparam int N = tsch_pkg::SLOTS;
    localparam int FW = $bits(tsch_pkg::tsch_frame_t);

    // register file
    logic [2:0] ctrl_r;
    logic [31:0] preset_r;
    logic [31:0] adj_r;
    logic [31:0] synct_r;
    logic sync_pend_r;
    logic [7:0] scfg_r [N];
    logic [28:0] sid_r [N];
    logic [31:0] sdlo_r [N];
    logic [31:0] sdhi_r [N];
    logic [31:0] sper_r [N];
    logic [31:0] sdly_r [N];

    logic req;
    logic wr_en;
    logic [11:0] soff;
    logic [tsch_pkg::SLOT_W-1:0] sidx;
    logic [2:0] sreg;
    logic in_slots;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en = req && wb_we_i;
    assign soff = wb_adr_i - tsch_pkg::SLOT_BASE;
    assign sidx = soff[9:5];
    assign sreg = soff[4:2];
    assign in_slots = (wb_adr_i >= tsch_pkg::SLOT_BASE) &&
                      (32'(sidx) < N) && (soff[11:10] == 2'b00);

    function automatic logic [31:0] bmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r <= tsch_pkg::CTRL_RST;
            preset_r <= '0;
            adj_r <= '0;
        end else if (wr_en && wb_adr_i == tsch_pkg::CTRL_OFS) begin
            ctrl_r <= 3'(bmerge({29'h0, ctrl_r}, wb_dat_i, wb_sel_i));
        end else if (wr_en && wb_adr_i == tsch_pkg::PRESET_OFS) begin
            preset_r <= bmerge(preset_r, wb_dat_i, wb_sel_i);
        end else if (wr_en && wb_adr_i == tsch_pkg::ADJ_OFS) begin
            adj_r <= bmerge(adj_r, wb_dat_i, wb_sel_i);
        end
    end

    // slot tables carry no reset: nothing uses them until run is set
    always_ff @(posedge core_clk_i) begin
        if (wr_en && in_slots) begin
            case (sreg)
                tsch_pkg::S_CFG: scfg_r[sidx] <=
                    8'(bmerge({24'h0, scfg_r[sidx]}, wb_dat_i, wb_sel_i));
                tsch_pkg::S_ID: sid_r[sidx] <=
                    29'(bmerge({3'h0, sid_r[sidx]}, wb_dat_i, wb_sel_i));
                tsch_pkg::S_DLO: sdlo_r[sidx] <=
                    bmerge(sdlo_r[sidx], wb_dat_i, wb_sel_i);
                tsch_pkg::S_DHI: sdhi_r[sidx] <=
                    bmerge(sdhi_r[sidx], wb_dat_i, wb_sel_i);
                tsch_pkg::S_PER: sper_r[sidx] <=
                    bmerge(sper_r[sidx], wb_dat_i, wb_sel_i);
                tsch_pkg::S_DLY: sdly_r[sidx] <=
                    bmerge(sdly_r[sidx], wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    // scheduler state
    logic [N-1:0] act_r;
    logic [N-1:0] pend_r;
    logic [N-1:0] due;
    logic [31:0] cnt_r [N];
    logic run_q_r;
    logic run_rise;
    logic [17:0] pre_r;
    logic tick;
    tsch_pkg::tsch_rtc_st_t rtc_st_r;
    logic [31:0] rd_nxt;

    assign run_rise = ctrl_r[tsch_pkg::CTRL_RUN] && !run_q_r;
    assign tick = (pre_r == 18'(TICK_CYCLES - 1));

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (in_slots) begin
            case (sreg)
                tsch_pkg::S_CFG: rd_nxt = {24'h0, scfg_r[sidx]};
                tsch_pkg::S_ID: rd_nxt = {3'h0, sid_r[sidx]};
                tsch_pkg::S_DLO: rd_nxt = sdlo_r[sidx];
                tsch_pkg::S_DHI: rd_nxt = sdhi_r[sidx];
                tsch_pkg::S_PER: rd_nxt = sper_r[sidx];
                tsch_pkg::S_DLY: rd_nxt = sdly_r[sidx];
                default: rd_nxt = 32'h0000_0000;
            endcase
        end else begin
            case (wb_adr_i)
                tsch_pkg::CTRL_OFS: rd_nxt = {29'h0, ctrl_r};
                tsch_pkg::STAT_OFS: rd_nxt = {9'h0, sync_pend_r,
                    rtc_st_r == tsch_pkg::RTC_RUN, |pend_r, act_r};
                tsch_pkg::PRESET_OFS: rd_nxt = preset_r;
                tsch_pkg::ADJ_OFS: rd_nxt = adj_r;
                tsch_pkg::WALL_OFS: rd_nxt = wall_time_o;
                tsch_pkg::SYNCT_OFS: rd_nxt = synct_r;
                default: rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    // every access, mapped or not, is acked one cycle after the strobe
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    // prescaler restarts at run so the first tick is a full 10 ms away
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_r <= '0;
            run_q_r <= 1'b0;
        end else begin
            run_q_r <= ctrl_r[tsch_pkg::CTRL_RUN];
            if (tick || run_rise) begin
                pre_r <= '0;
            end else begin
                pre_r <= pre_r + 1'b1;
            end
        end
    end

    // arbitration: lowest pending slot wins
    logic [tsch_pkg::SLOT_W-1:0] gidx;
    logic push_v;
    logic f_in_ready;
    logic [N-1:0] grant;
    tsch_pkg::tsch_frame_t push_f;

    always_comb begin
        gidx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend_r[i]) begin
                gidx = 5'(i);
            end
        end
    end
    assign push_v = |pend_r;
    assign grant = (push_v && f_in_ready) ? (N'(1) << gidx) : '0;

    always_comb begin
        push_f.slot = gidx;
        push_f.route = scfg_r[gidx][tsch_pkg::SCFG_ROUTE_LO +: 2];
        push_f.long_identifier_select = scfg_r[gidx][tsch_pkg::SCFG_EXT];
        push_f.frame_identifier = sid_r[gidx];
        if (!scfg_r[gidx][tsch_pkg::SCFG_EXT]) begin
            push_f.frame_identifier[28:tsch_pkg::STD_ID_W] = '0;
        end
        push_f.len = scfg_r[gidx][tsch_pkg::SCFG_LEN_LO +: 4];
        if (push_f.len > 4'(tsch_pkg::MAX_LEN)) begin
            push_f.len = 4'(tsch_pkg::MAX_LEN);
        end
        push_f.payload_bytes = {sdhi_r[gidx], sdlo_r[gidx]};
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_slot
            assign due[g] = act_r[g] && (cnt_r[g] == 32'h0000_0000);
            always_ff @(posedge core_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    act_r[g] <= 1'b0;
                    cnt_r[g] <= '0;
                end else if (!ctrl_r[tsch_pkg::CTRL_RUN]) begin
                    act_r[g] <= 1'b0;
                end else if (run_rise) begin
                    act_r[g] <= scfg_r[g][tsch_pkg::SCFG_EN];
                    cnt_r[g] <= sdly_r[g];
                end else if (due[g]) begin
                    cnt_r[g] <= sper_r[g];
                    if (sper_r[g] == 32'h0000_0000) begin
                        act_r[g] <= 1'b0;
                    end
                end else if (tick && act_r[g]) begin
                    cnt_r[g] <= cnt_r[g] - 1'b1;
                end
            end
            // a fresh due in the grant cycle keeps the slot pending
            always_ff @(posedge core_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    pend_r[g] <= 1'b0;
                end else if (due[g]) begin
                    pend_r[g] <= 1'b1;
                end else if (grant[g]) begin
                    pend_r[g] <= 1'b0;
                end
            end

            property p_start_delay;
                @(posedge core_clk_i) disable iff (!rst_b_i)
                run_rise |=> cnt_r[g] == $past(sdly_r[g]);
            endproperty
            a_start_delay: assert property (p_start_delay)
                else $error("slot counter not loaded with its delay");

            property p_single_shot;
                @(posedge core_clk_i) disable iff (!rst_b_i)
                due[g] && sper_r[g] == 0 && !run_rise
                |=> !act_r[g] ##1 !due[g];
            endproperty
            a_single_shot: assert property (p_single_shot)
                else $error("single shot slot stayed active");

            property p_period_reload;
                @(posedge core_clk_i) disable iff (!rst_b_i)
                due[g] && sper_r[g] != 0 && ctrl_r[0] && !run_rise
                |=> act_r[g] && cnt_r[g] == $past(sper_r[g]) && pend_r[g];
            endproperty
            a_period_reload: assert property (p_period_reload)
                else $error("periodic slot not reloaded");
        end
    endgenerate

    tsch_pkg::tsch_frame_t f_out;
    logic f_valid;
    logic f_pop;
    assign f_pop = !tx_valid_o || tx_ready_i;

    tsch_fifo #(
        .WIDTH(FW),
        .DEPTH(tsch_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(push_v),
        .in_ready_o(f_in_ready),
        .in_data_i(push_f),
        .out_valid_o(f_valid),
        .out_ready_i(f_pop),
        .out_data_o(f_out)
    );

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_valid_o <= 1'b0;
            tx_frame_o <= '0;
            tx_log_copy_o <= 1'b0;
            tx_host_copy_o <= 1'b0;
        end else if (f_pop) begin
            tx_valid_o <= f_valid;
            tx_frame_o <= f_out;
            tx_log_copy_o <= f_valid && f_out.route[0];
            tx_host_copy_o <= f_valid && f_out.route[1];
        end
    end

    // wall clock lives on the backup reset so it survives power loss
    logic [6:0] sub_r;
    logic [11:0] hr_r;
    logic sec_tick;
    logic signed [32:0] adj_c;
    logic [31:0] base_c;
    assign sec_tick = tick && (sub_r == 7'(tsch_pkg::TICKS_PER_S - 1));

    always_comb begin
        if ($signed(adj_r) > tsch_pkg::ADJ_MAX) begin
            adj_c = 33'(tsch_pkg::ADJ_MAX);
        end else if ($signed(adj_r) < -tsch_pkg::ADJ_MAX) begin
            adj_c = -33'(tsch_pkg::ADJ_MAX);
        end else begin
            adj_c = {adj_r[31], adj_r};
        end
        if (preset_r != 32'h0000_0000) begin
            base_c = preset_r;
        end else if (sync_pend_r) begin
            base_c = synct_r;
        end else begin
            base_c = wall_time_o;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rtc_st_r <= tsch_pkg::RTC_WAIT;
            sub_r <= '0;
            hr_r <= '0;
            sync_req_o <= 1'b0;
        end else begin
            sync_req_o <= 1'b0;
            if (tick) begin
                sub_r <= sec_tick ? 7'h00 : sub_r + 1'b1;
            end
            case (rtc_st_r)
                tsch_pkg::RTC_WAIT: begin
                    if (ctrl_r[tsch_pkg::CTRL_CFG_DONE]) begin
                        rtc_st_r <= tsch_pkg::RTC_ADJ;
                    end
                end
                tsch_pkg::RTC_ADJ: rtc_st_r <= tsch_pkg::RTC_RUN;
                tsch_pkg::RTC_RUN: begin
                    if (sec_tick && ctrl_r[tsch_pkg::CTRL_SYNC_ON]) begin
                        if (hr_r == 12'(tsch_pkg::SYNC_S - 1)) begin
                            hr_r <= '0;
                            sync_req_o <= 1'b1;
                        end else begin
                            hr_r <= hr_r + 1'b1;
                        end
                    end
                end
                default: rtc_st_r <= tsch_pkg::RTC_WAIT;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge bkp_rst_b_i) begin
        if (!bkp_rst_b_i) begin
            wall_time_o <= '0;
            synct_r <= '0;
            sync_pend_r <= 1'b0;
        end else begin
            if (rtc_st_r == tsch_pkg::RTC_ADJ) begin
                wall_time_o <= 32'($signed({1'b0, base_c}) + adj_c);
            end else if (sec_tick) begin
                wall_time_o <= wall_time_o + 1'b1;
            end
            if (wr_en && wb_adr_i == tsch_pkg::SYNCT_OFS) begin
                synct_r <= bmerge(synct_r, wb_dat_i, wb_sel_i);
                sync_pend_r <= 1'b1;
            end else if (rtc_st_r == tsch_pkg::RTC_ADJ) begin
                sync_pend_r <= 1'b0;
            end
        end
    end

    property p_preset_load;
        @(posedge core_clk_i) disable iff (!rst_b_i || !bkp_rst_b_i)
        rtc_st_r == tsch_pkg::RTC_ADJ && preset_r != 0 && adj_r == 0
        |=> wall_time_o == $past(preset_r);
    endproperty
    a_preset_load: assert property (p_preset_load)
        else $error("nonzero preset not loaded at power-on");

    property p_lowest_first;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        push_v |-> (pend_r & ((N'(1) << gidx) - N'(1))) == '0;
    endproperty
    a_lowest_first: assert property (p_lowest_first)
        else $error("granted slot is not the lowest pending");

    property p_std_id;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        tx_valid_o && !tx_frame_o.long_identifier_select
        |-> tx_frame_o.frame_identifier[28:11] == 0 && tx_frame_o.len <= 8;
    endproperty
    a_std_id: assert property (p_std_id)
        else $error("standard frame carries a long identifier");

    property p_tick_spacing;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        tick |=> !tick [*2];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("ticks closer than the prescaler allows");

    property p_ack_pulse;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("wishbone ack not a one-cycle answer");
endmodule

// [test/tsch_can_model.sv]
// behavioural can controller: takes frames on valid/ready, logs them
// assumes the scheduler's clock; stall_i slows acceptance to 1 in 4
`timescale 1ns/1ps
module tsch_can_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // frame link
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire tsch_pkg::tsch_frame_t tx_frame_i,
    input wire logic log_copy_i,
    input wire logic host_copy_i,
    // test control
    input wire logic stall_i
);
    tsch_pkg::tsch_frame_t rx_q[$];
    logic [1:0] cp_q[$];
    logic [2:0] cnt_r;

    // ready is a level that may stand without valid, as a real core's does
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 3'h0;
            tx_ready_o <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
            tx_ready_o <= !stall_i || (cnt_r[1:0] == 2'h3);
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_b_i && tx_valid_i && tx_ready_o) begin
            rx_q.push_back(tx_frame_i);
            cp_q.push_back({host_copy_i, log_copy_i});
        end
    end
endmodule

// [test/tb.sv]
// bench: random slot tables, frame order and contents, wall clock loading
// assumes tsch_top with a short tick and the can model on its frame link
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    miscompares++; $display("mismatch %0t compare failed", $time); end end
module tb;
    logic clk = 0, rst_b = 0, bkp_b = 0, cyc = 0, stb = 0, we = 0;
    logic stall = 1;
    logic [11:0] adr = 12'h000;
    logic [11:0] b;
    logic [31:0] dat = 32'h0000_0000, rdat, rd, w, wt, st, wall;
    logic ack, txv, txr, logc, hostc, sreq;
    logic sreq_seen = 1'b0;
    tsch_pkg::tsch_frame_t txf;
    logic [7:0] cfg [20];
    logic [31:0] id [20], lo [20], hi [20], per [20], dly [20];
    int seed = 32'h0000_c40c;
    int miscompares = 0, checks_done = 0, cyc_cnt = 0;
    int exp_s[$];

    tsch_top #(.TICK_CYCLES(8)) i_tsch_top (.core_clk_i(clk),
        .rst_b_i(rst_b), .bkp_rst_b_i(bkp_b), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .tx_valid_o(txv), .tx_ready_i(txr), .tx_frame_o(txf),
        .tx_log_copy_o(logc), .tx_host_copy_o(hostc),
        .wall_time_o(wall), .sync_req_o(sreq));
    tsch_can_model i_tsch_can_model (.core_clk_i(clk), .rst_b_i(rst_b),
        .tx_valid_i(txv), .tx_ready_o(txr), .tx_frame_i(txf),
        .log_copy_i(logc), .host_copy_i(hostc), .stall_i(stall));

    initial forever #20 clk = ~clk;

    task automatic wbx(input logic w_en, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w_en;
        adr <= a;
        dat <= d;
        // only the cycle ceiling below ends a wait that never gets its ack
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdat = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    function automatic tsch_pkg::tsch_frame_t exp_f(input int s);
        tsch_pkg::tsch_frame_t f;
        f.slot = 5'(s);
        f.route = cfg[s][3:2];
        f.long_identifier_select = cfg[s][1];
        // standard frames carry only the low eleven identifier bits
        f.frame_identifier = cfg[s][1] ? id[s][28:0] : {18'h0_0000,
            id[s][10:0]};
        f.len = cfg[s][7:4];
        f.payload_bytes = {hi[s], lo[s]};
        return f;
    endfunction

    task finish_test;
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc_cnt++;
        stall <= cyc_cnt[4];
        if (sreq === 1'b1) begin
            sreq_seen = 1'b1;
        end
        if (cyc_cnt == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        bkp_b <= 1'b1;
        wbx(1'b0, 12'hff0, 32'h0000_0000);
        `CHK(rdat, 32'h0000_0000)
        for (int i = 0; i < 20; i++) begin
            id[i] = $random(seed);
            lo[i] = $random(seed);
            hi[i] = $random(seed);
            cfg[i] = 8'h00;
            per[i] = 32'h0000_0000;
            dly[i] = 32'h0000_0000;
        end
        cfg[0] = 8'h8f;
        cfg[1] = 8'h01;
        cfg[2] = 8'h35;
        cfg[19] = 8'h4b;
        per[2] = 32'h0000_0003;
        dly[2] = 32'h0000_0001;
        dly[19] = 32'h0000_0002;
        for (int i = 0; i < 20; i++) begin
            b = 12'h100 + 12'(i * 32);
            wbx(1'b1, b, {24'h00_0000, cfg[i]});
            wbx(1'b1, b + 12'h004, id[i]);
            wbx(1'b1, b + 12'h008, lo[i]);
            wbx(1'b1, b + 12'h00c, hi[i]);
            wbx(1'b1, b + 12'h010, per[i]);
            wbx(1'b1, b + 12'h014, dly[i]);
        end
        wt = $random(seed) | 32'h4000_0000;
        wbx(1'b1, 12'h008, wt);
        wbx(1'b1, 12'h00c, 32'h0003_0d40);
        wbx(1'b1, 12'h000, 32'h0000_0003);
        wbx(1'b0, 12'h010, 32'h0000_0000);
        `CHK(rdat, wt + 32'h0001_fa40)
        repeat (308) @(posedge clk);
        exp_s = '{0, 1, 2, 19};
        for (int i = 0; i < 12; i++) exp_s.push_back(2);
        `CHK(i_tsch_can_model.rx_q.size(), 16)
        foreach (exp_s[k]) if (k < i_tsch_can_model.rx_q.size()) begin
            `CHK(i_tsch_can_model.rx_q[k], exp_f(exp_s[k]))
            `CHK(i_tsch_can_model.cp_q[k], cfg[exp_s[k]][3:2])
        end
        // single shots are done, the periodic slot stays active
        wbx(1'b0, 12'h004, 32'h0000_0000);
        `CHK(rdat, 32'h0020_0004)
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        wbx(1'b0, 12'h010, 32'h0000_0000);
        w = rdat;
        `CHK(w - wt - 32'h0001_fa40 < 32'h0000_0002, 1'b1)
        `CHK(wall - w < 32'h0000_0002, 1'b1)
        // preset and offset live in the power-on domain: reload after reset
        wbx(1'b1, 12'h008, 32'h0000_0000);
        wbx(1'b1, 12'h00c, 32'hffff_fffb);
        wbx(1'b1, 12'h000, 32'h0000_0002);
        wbx(1'b0, 12'h010, 32'h0000_0000);
        `CHK(rdat == w - 32'd5 || rdat == w - 32'd4, 1'b1)
        st = $random(seed);
        wbx(1'b1, 12'h014, st);
        wbx(1'b0, 12'h004, 32'h0000_0000);
        `CHK(rdat[22], 1'b1)
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        wbx(1'b1, 12'h000, 32'h0000_0002);
        wbx(1'b0, 12'h010, 32'h0000_0000);
        `CHK(rdat - st < 32'h0000_0002, 1'b1)
        `CHK(sreq_seen, 1'b0)
        finish_test();
    end
endmodule
